// file: logic/shc_pkg.sv
// Purpose: Constants and types for the SECDED Hamming codec
// Assumes: APB word-aligned register map, 100 MHz ref_clk_i
// Notes:   Offsets are byte addresses
`default_nettype none
package shc_pkg;
	// Register byte offsets
	localparam logic [7:0] ADDR_CTRL  = 8'h00;
	localparam logic [7:0] ADDR_INFO  = 8'h04;
	localparam logic [7:0] ADDR_SADDR = 8'h08;
	localparam logic [7:0] ADDR_WDATA = 8'h0C;
	localparam logic [7:0] ADDR_ENC   = 8'h10;
	localparam logic [7:0] ADDR_CODE  = 8'h14;
	localparam logic [7:0] ADDR_DEC   = 8'h18;
	localparam logic [7:0] ADDR_CMD   = 8'h1C;
	localparam logic [7:0] ADDR_STAT  = 8'h20;
	localparam logic [7:0] ADDR_ISTAT = 8'h24;
	localparam logic [7:0] ADDR_IMASK = 8'h28;
	// Field positions
	localparam int CTRL_DET_BIT  = 4;
	localparam int INFO_CW_LSB   = 4;
	localparam int INFO_TWO_BIT  = 12;
	localparam int DEC_STAT_LSB  = 16;
	localparam int CMD_STORE_BIT = 0;
	localparam int CMD_FETCH_BIT = 1;
	localparam int STAT_ERR_LSB  = 4;
	// Interrupt bits
	localparam int IRQ_ENC  = 0;
	localparam int IRQ_DEC  = 1;
	localparam int IRQ_OP   = 2;
	localparam int IRQ_DERR = 3;
	localparam int IRQ_W    = 4;
	// Reset values and limits
	localparam logic [3:0]  WIDTH_RST = 4'h8;
	localparam logic [3:0]  WIDTH_MAX = 4'hB;
	localparam logic [15:0] SADDR_RST = 16'h0000;
	// Decode status codes
	localparam logic [1:0] ST_OK   = 2'h0;
	localparam logic [1:0] ST_CORR = 2'h1;
	localparam logic [1:0] ST_DBL  = 2'h2;
	// Store sequencer states
	typedef enum logic [5:0] {
		SQ_IDLE  = 6'b000001,
		SQ_WR_LO = 6'b000010,
		SQ_WR_HI = 6'b000100,
		SQ_RB_LO = 6'b001000,
		SQ_RB_HI = 6'b010000,
		SQ_DONE  = 6'b100000
	} shc_seq_t;
endpackage : shc_pkg
`default_nettype wire

// file: logic/shc_codec.sv
// Purpose: SECDED Hamming codec, 1..11 data bits, byte-store sequencer
// Assumes: APB slave on ref_clk_i; store port logic on the same clock
// Notes:   One wait state on every APB access
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// [RULE1] Check bits: least k with 2^k >= m+k+1
// [RULE2] Eight data bits use four check bits
// [RULE3] Matrix column j equals binary j
// [RULE4] Checks at power-of-two columns, data ascending
// [RULE5] Check bit xors data with row one
// [RULE6] Eight-bit check equations as given
// [RULE7] Syndrome weighted one, two, four, eight
// [RULE8] Nonzero syndrome inverts the named column
// [RULE9] Overall parity bit after last data bit
// [RULE10] Parity fail correctable, parity pass double
// [RULE11] Encoded widths 4,6,7,8,10..16 bits
// [RULE12] Stored as one or two whole bytes
// [RULE13] Status 0 none, 1 corrected, 2 double
// [RULE14] Detect-only mode leaves data unaltered
// [RULE15] Width reload updates all derived sizes
// [RULE16] Address advances by storage size
// [RULE17] Store followed by read-back decode status
// [RULE18] Low byte at lower address first
// [RULE19] Results registered one cycle, cleared reset
module shc_codec (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// APB slave
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output var  logic [31:0] prdata_o,
	output var  logic        pready_o,
	output var  logic        pslverr_o,
	// Byte store port
	output var  logic        st_req_o,
	output var  logic        st_we_o,
	output var  logic [15:0] st_addr_o,
	output var  logic [7:0]  st_wdata_o,
	input  wire logic        st_ack_i,
	input  wire logic [7:0]  st_rdata_i,
	// Interrupt
	output var  logic        irq_o
);

	function automatic logic [2:0] f_checks(input logic [3:0] m);
		logic [2:0] k;
		k = 3'h1;
		for (int i = 0; i < 4; i++) begin
			if ((5'h1 << k) < ({1'b0, m} + {2'b0, k} + 5'h1))
				k = k + 3'h1;
		end
		return k;
	endfunction : f_checks

	function automatic logic [15:0] f_encode(input logic [10:0] d, input logic [3:0] m,
		input logic [4:0] n);
		logic [15:0] c;
		logic [3:0]  dp;
		logic        p;
		c  = 16'h0000;
		dp = 4'h0;
		for (int j = 1; j < 16; j++) begin
			if ((j & (j - 1)) != 0 && dp < m) begin
				c[j-1] = d[dp]; // [RULE4]
				dp     = dp + 4'h1;
			end
		end
		for (int i = 0; i < 4; i++) begin
			p = 1'b0;
			for (int j = 1; j < 16; j++) begin
				if (j[i] && (j & (j - 1)) != 0)
					p = p ^ c[j-1]; // [RULE3] [RULE5] [RULE6]
			end
			if ((1 << i) <= n)
				c[(1 << i) - 1] = p;
		end
		c[n[3:0]] = ^c; // [RULE9]
		return c;
	endfunction : f_encode

	function automatic logic [12:0] f_decode(input logic [15:0] cw, input logic [3:0] m,
		input logic [4:0] n, input logic det);
		logic [15:0] c;
		logic [3:0]  syn;
		logic        par;
		logic [1:0]  st;
		logic [10:0] d;
		logic [3:0]  dp;
		c   = cw;
		syn = 4'h0;
		par = 1'b0;
		d   = 11'h000;
		dp  = 4'h0;
		for (int j = 1; j < 17; j++) begin
			if (j <= n && c[j-1])
				syn = syn ^ j[3:0]; // [RULE7]
			if (j <= n + 1)
				par = par ^ c[j-1];
		end
		if (syn == 4'h0)
			st = par ? shc_pkg::ST_CORR : shc_pkg::ST_OK;
		else
			st = par ? shc_pkg::ST_CORR : shc_pkg::ST_DBL; // [RULE10]
		if (!det && par && syn != 4'h0 && {1'b0, syn} <= n) // [RULE8] [RULE14]
			c[syn - 4'h1] = ~c[syn - 4'h1];
		for (int j = 1; j < 16; j++) begin
			if ((j & (j - 1)) != 0 && dp < m) begin
				d[dp] = c[j-1];
				dp    = dp + 4'h1;
			end
		end
		return {st, d};
	endfunction : f_decode

	logic [3:0]  width_r;
	logic        det_r;
	logic [15:0] saddr_r;
	logic [15:0] op_addr_r;
	logic [10:0] wdata_r;
	logic [15:0] enc_r;
	logic [10:0] dec_data_r;
	logic [1:0]  dec_stat_r;
	logic [1:0]  op_stat_r;
	logic [15:0] rb_code_r;
	logic [shc_pkg::IRQ_W-1:0] istat_r;
	logic [shc_pkg::IRQ_W-1:0] imask_r;
	logic [shc_pkg::IRQ_W-1:0] iset;
	logic        enc_go_r;
	logic        dec_go;
	logic        op_store_r;
	logic        op_done_r;
	shc_pkg::shc_seq_t seq_r;
	logic [2:0]  k_w;
	logic [4:0]  code_w;
	logic        two_byte_storage_flag;
	logic [15:0] op_code;
	logic [12:0] dec_res;
	logic [12:0] rb_res;
	logic [31:0] rd_data;
	logic        rd_err;
	logic        apb_wr;
	logic        busy;

	assign k_w                   = f_checks(width_r); // [RULE1] [RULE2] [RULE15]
	assign code_w                = {1'b0, width_r} + {2'b0, k_w} + 5'h01; // [RULE11]
	assign two_byte_storage_flag = (code_w > 5'h08); // [RULE12]
	assign op_code               = f_encode(wdata_r, width_r, code_w - 5'h01);
	assign dec_res  = f_decode(pwdata_i[15:0], width_r, code_w - 5'h01, det_r);
	assign rb_res   = f_decode(rb_code_r, width_r, code_w - 5'h01, det_r); // [RULE17]
	assign busy     = (seq_r != shc_pkg::SQ_IDLE);
	assign apb_wr   = psel_i && penable_i && pwrite_i && pready_o;
	assign dec_go   = apb_wr && paddr_i == shc_pkg::ADDR_CODE;
	assign iset     = {op_done_r && op_stat_r == shc_pkg::ST_DBL, op_done_r, dec_go, enc_go_r};

	// Register read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_err  = 1'b0;
		case (paddr_i)
			shc_pkg::ADDR_CTRL:  rd_data = {27'h0, det_r, width_r};
			shc_pkg::ADDR_INFO:  rd_data = {19'h0, two_byte_storage_flag, 3'h0, code_w, 1'b0, k_w};
			shc_pkg::ADDR_SADDR: rd_data = {16'h0, saddr_r};
			shc_pkg::ADDR_WDATA: rd_data = {21'h0, wdata_r};
			shc_pkg::ADDR_ENC:   rd_data = {16'h0, enc_r};
			shc_pkg::ADDR_CODE:  rd_data = {16'h0, rb_code_r};
			shc_pkg::ADDR_DEC:   rd_data = {14'h0, dec_stat_r, 5'h0, dec_data_r};
			shc_pkg::ADDR_CMD:   rd_data = 32'h0000_0000;
			shc_pkg::ADDR_STAT:  rd_data = {26'h0, op_stat_r, 3'h0, busy};
			shc_pkg::ADDR_ISTAT: rd_data = {28'h0, istat_r};
			shc_pkg::ADDR_IMASK: rd_data = {28'h0, imask_r};
			default:    rd_err  = 1'b1;
		endcase
	end

	// APB handshake, one wait state
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			pready_o  <= 1'b0;
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else begin
			pready_o <= psel_i && penable_i && !pready_o;
			if (psel_i && penable_i && !pready_o) begin
				prdata_o  <= pwrite_i ? 32'h0000_0000 : rd_data;
				pslverr_o <= rd_err;
			end else begin
				pslverr_o <= 1'b0;
			end
		end
	end

	// Configuration; width, mode and data writes ignored while a store or fetch runs, mask writes always taken
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			width_r <= shc_pkg::WIDTH_RST;
			det_r   <= 1'b0;
			imask_r <= '0;
			wdata_r <= 11'h000;
		end else if (apb_wr) begin
			if (paddr_i == shc_pkg::ADDR_CTRL && !busy && pwdata_i[3:0] != 4'h0
				&& pwdata_i[3:0] <= shc_pkg::WIDTH_MAX) begin
				width_r <= pwdata_i[3:0]; // [RULE15]
				det_r   <= pwdata_i[shc_pkg::CTRL_DET_BIT];
			end
			if (paddr_i == shc_pkg::ADDR_IMASK)
				imask_r <= pwdata_i[shc_pkg::IRQ_W-1:0];
			if (paddr_i == shc_pkg::ADDR_WDATA && !busy)
				wdata_r <= pwdata_i[10:0];
		end
	end

	// Encode and direct decode results
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			enc_go_r   <= 1'b0;
			enc_r      <= 16'h0000;
			dec_data_r <= 11'h000;
			dec_stat_r <= shc_pkg::ST_OK; // [RULE19]
		end else begin
			enc_go_r <= apb_wr && paddr_i == shc_pkg::ADDR_WDATA && !busy;
			if (enc_go_r)
				enc_r <= op_code; // [RULE19]
			if (dec_go) begin
				dec_data_r <= dec_res[10:0];
				dec_stat_r <= dec_res[12:11]; // [RULE13]
			end else if (op_done_r) begin
				dec_data_r <= rb_res[10:0];
				dec_stat_r <= rb_res[12:11];
			end
		end
	end

	// Store and fetch sequencer
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			seq_r      <= shc_pkg::SQ_IDLE;
			st_req_o   <= 1'b0;
			st_we_o    <= 1'b0;
			st_addr_o  <= 16'h0000;
			st_wdata_o <= 8'h00;
			op_addr_r  <= 16'h0000;
			op_store_r <= 1'b0;
			rb_code_r  <= 16'h0000;
			op_done_r  <= 1'b0;
		end else begin
			op_done_r <= 1'b0;
			case (seq_r)
				shc_pkg::SQ_IDLE: begin
					if (apb_wr && paddr_i == shc_pkg::ADDR_CMD
						&& (pwdata_i[shc_pkg::CMD_STORE_BIT]
						|| pwdata_i[shc_pkg::CMD_FETCH_BIT])) begin
						op_addr_r  <= saddr_r;
						op_store_r <= pwdata_i[shc_pkg::CMD_STORE_BIT];
						rb_code_r  <= 16'h0000;
						st_req_o   <= 1'b1;
						st_addr_o  <= saddr_r;
						st_we_o    <= pwdata_i[shc_pkg::CMD_STORE_BIT];
						st_wdata_o <= op_code[7:0]; // [RULE18]
						seq_r      <= pwdata_i[shc_pkg::CMD_STORE_BIT] ?
							shc_pkg::SQ_WR_LO : shc_pkg::SQ_RB_LO;
					end
				end
				shc_pkg::SQ_WR_LO: begin
					if (st_ack_i) begin
						if (two_byte_storage_flag) begin
							st_addr_o  <= op_addr_r + 16'h0001; // [RULE18]
							st_wdata_o <= op_code[15:8];
							seq_r      <= shc_pkg::SQ_WR_HI;
						end else begin
							st_addr_o <= op_addr_r; // [RULE17]
							st_we_o   <= 1'b0;
							seq_r     <= shc_pkg::SQ_RB_LO;
						end
					end
				end
				shc_pkg::SQ_WR_HI: begin
					if (st_ack_i) begin
						st_addr_o <= op_addr_r; // [RULE17]
						st_we_o   <= 1'b0;
						seq_r     <= shc_pkg::SQ_RB_LO;
					end
				end
				shc_pkg::SQ_RB_LO: begin
					if (st_ack_i) begin
						rb_code_r[7:0] <= st_rdata_i;
						if (two_byte_storage_flag) begin
							st_addr_o <= op_addr_r + 16'h0001;
							seq_r     <= shc_pkg::SQ_RB_HI;
						end else begin
							st_req_o <= 1'b0;
							seq_r    <= shc_pkg::SQ_DONE;
						end
					end
				end
				shc_pkg::SQ_RB_HI: begin
					if (st_ack_i) begin
						rb_code_r[15:8] <= st_rdata_i;
						st_req_o        <= 1'b0;
						seq_r           <= shc_pkg::SQ_DONE;
					end
				end
				shc_pkg::SQ_DONE: begin
					op_done_r <= 1'b1;
					seq_r     <= shc_pkg::SQ_IDLE;
				end
				default: begin
					st_req_o <= 1'b0;
					seq_r    <= shc_pkg::SQ_IDLE;
				end
			endcase
		end
	end

	// Storage address and operation status
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			saddr_r   <= shc_pkg::SADDR_RST;
			op_stat_r <= shc_pkg::ST_OK;
		end else if (seq_r == shc_pkg::SQ_DONE) begin
			saddr_r   <= op_addr_r + (two_byte_storage_flag ? 16'h0002 : 16'h0001); // [RULE16]
			op_stat_r <= rb_res[12:11]; // [RULE17]
		end else if (apb_wr && paddr_i == shc_pkg::ADDR_SADDR && !busy) begin
			saddr_r <= pwdata_i[15:0];
		end
	end

	// Sticky interrupt status, set wins over write-one-clear
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			istat_r <= '0;
			irq_o   <= 1'b0;
		end else begin
			istat_r <= (istat_r & ~((apb_wr && paddr_i == shc_pkg::ADDR_ISTAT) ?
				pwdata_i[shc_pkg::IRQ_W-1:0] : '0)) | iset;
			irq_o   <= |(istat_r & imask_r);
		end
	end

	AST_K_MIN: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE1]
		((6'h01 << k_w) >= {2'b0, width_r} + {3'b0, k_w} + 6'h01) &&
		((6'h01 << (k_w - 3'h1)) < {2'b0, width_r} + {3'b0, k_w}))
		else $error("check bit count not minimal");
	AST_K_EIGHT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE2]
		width_r == 4'h8 |-> k_w == 3'h4 && code_w == 5'h0D)
		else $error("eight data bits need four check bits");
	AST_TWO_BYTE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE12]
		two_byte_storage_flag == (width_r > 4'h4))
		else $error("storage size wrong for width");
	AST_CHK_EIGHT: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE6]
		enc_go_r && width_r == 4'h8 |=> enc_r[0] == ^{$past(wdata_r[0]), $past(wdata_r[1]),
		$past(wdata_r[3]), $past(wdata_r[4]), $past(wdata_r[6])} &&
		enc_r[7] == ^$past(wdata_r[7:4]) && enc_r[12] == ^enc_r[11:0])
		else $error("eight bit check equations broken");
	AST_DBL_FLAG: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE10]
		dec_go && dec_res[12:11] == shc_pkg::ST_DBL |=> dec_stat_r == shc_pkg::ST_DBL &&
		istat_r[shc_pkg::IRQ_DEC])
		else $error("double error not reported");
	AST_STAT_RANGE: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE13]
		dec_stat_r != 2'h3 && op_stat_r != 2'h3)
		else $error("illegal decode status");
	AST_ADDR_STEP: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE16]
		seq_r == shc_pkg::SQ_DONE |=>
		saddr_r == op_addr_r + (two_byte_storage_flag ? 16'h0002 : 16'h0001))
		else $error("storage address did not advance by size");
	AST_HI_ADDR: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE18]
		seq_r == shc_pkg::SQ_WR_HI |-> st_we_o && st_addr_o == op_addr_r + 16'h0001)
		else $error("high byte not at following address");
	AST_READBACK: assert property (@(posedge ref_clk_i) disable iff (!nrst_i) // [RULE17]
		seq_r == shc_pkg::SQ_WR_LO && st_ack_i && !two_byte_storage_flag |=>
		seq_r == shc_pkg::SQ_RB_LO && !st_we_o)
		else $error("store not followed by read-back");
	AST_RESET_CLR: assert property (@(posedge ref_clk_i) // [RULE19]
		!nrst_i |=> enc_r == 16'h0000 && dec_stat_r == shc_pkg::ST_OK && !irq_o)
		else $error("results not cleared by reset");

endmodule : shc_codec
`default_nettype wire

// file: verif/shc_store_model.sv
// Purpose: Byte-wide store model on the far side of the codec store port
// Assumes: Same clock as the codec, transfer at edge with request and ack high
// Notes:   Read data is only valid in the ack cycle
`timescale 1ns/100ps
`default_nettype none
module shc_store_model (
	// Clock and reset
	input  wire logic        ref_clk_i,
	input  wire logic        nrst_i,
	// Test controls
	input  wire logic        slow_i,
	input  wire logic [7:0]  flip_mask_i,
	// Byte store port
	input  wire logic        st_req_i,
	input  wire logic        st_we_i,
	input  wire logic [15:0] st_addr_i,
	input  wire logic [7:0]  st_wdata_i,
	output var  logic        st_ack_o,
	output var  logic [7:0]  st_rdata_o
);
	logic [7:0] mem [0:255];
	logic [1:0] gap_r;
	// Slow mode leaves gaps; bytes at even addresses may be corrupted on read
	always_ff @(posedge ref_clk_i) begin
		if (!nrst_i) begin
			st_ack_o   <= 1'b0;
			gap_r      <= 2'h0;
			st_rdata_o <= 8'h00;
		end else if (st_req_i && !st_ack_o && gap_r == 2'h0) begin
			st_ack_o   <= 1'b1;
			gap_r      <= slow_i ? 2'h3 : 2'h0;
			st_rdata_o <= mem[st_addr_i[7:0]] ^ (st_addr_i[0] ? 8'h00 : flip_mask_i);
		end else begin
			st_ack_o   <= 1'b0;
			st_rdata_o <= ~st_rdata_o;
			if (gap_r != 2'h0) gap_r <= gap_r - 2'h1;
		end
	end
	// Byte written at the ack edge
	always_ff @(posedge ref_clk_i) begin
		if (st_req_i && st_ack_o && st_we_i) mem[st_addr_i[7:0]] <= st_wdata_i;
	end
endmodule : shc_store_model
`default_nettype wire

// file: verif/secded_hamming_codec_bench.sv
// Purpose: Self-checking bench for the SECDED codec
// Assumes: APB master and byte store model on ref_clk_i
// Notes:   Random data from a shift register seeded at 25
`timescale 1ns/100ps
`default_nettype none
module secded_hamming_codec_bench;
	logic        ref_clk_i = 1'b0, nrst_i = 1'b0, slow = 1'b0;
	logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00, flip = 8'h00;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rv;
	logic        pready_o, pslverr_o, st_req_o, st_we_o, st_ack_i, irq_o, lerr;
	logic [15:0] st_addr_o, seed = 16'h0019;
	logic [7:0]  st_wdata_o, st_rdata_i;
	int          errors = 0, check_count = 0;
	always #5 ref_clk_i = ~ref_clk_i;
	shc_codec i_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .st_req_o(st_req_o),
		.st_we_o(st_we_o), .st_addr_o(st_addr_o), .st_wdata_o(st_wdata_o),
		.st_ack_i(st_ack_i), .st_rdata_i(st_rdata_i), .irq_o(irq_o));
	shc_store_model i_mem (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .slow_i(slow),
		.flip_mask_i(flip), .st_req_i(st_req_o), .st_we_i(st_we_o), .st_addr_i(st_addr_o),
		.st_wdata_i(st_wdata_o), .st_ack_o(st_ack_i), .st_rdata_o(st_rdata_i));
	task automatic close_out();
		$display("mismatches %0d of %0d compares", errors, check_count);
		if (errors == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [15:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed;
	endfunction : rnd
	function automatic int kof(input int m);
		int k;
		k = 1;
		while ((1 << k) < m + k + 1) k++;
		return k;
	endfunction : kof
	function automatic logic [15:0] enc(input int m, input logic [10:0] d);
		logic [15:0] c;
		int          k, i, j, p;
		k = kof(m);
		c = 16'h0;
		i = 0;
		for (j = 1; j <= m + k; j++) if ((j & (j - 1)) != 0) begin
			c[j - 1] = d[i];
			i++;
		end
		for (p = 0; p < k; p++) for (j = 1; j <= m + k; j++) begin
			if ((j & (j - 1)) != 0 && j[p]) c[(1 << p) - 1] ^= c[j - 1];
		end
		c[m + k] = ^c;
		return c;
	endfunction : enc
	function automatic logic [31:0] info(input int m);
		int cw;
		cw = m + kof(m) + 1;
		return {19'h0, cw > 8, 3'h0, 5'(cw), 1'b0, 3'(kof(m))};
	endfunction : info
	function automatic logic [31:0] dec(input logic [10:0] d, input logic [1:0] s);
		return {14'h0, s, 5'h0, d};
	endfunction : dec
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk_i);
		psel_i    <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i  <= w;
		paddr_i   <= a;
		pwdata_i  <= d;
		@(posedge ref_clk_i);
		penable_i <= 1'b1;
		do begin
			@(posedge ref_clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 20);
		rv = prdata_o;
		lerr = pslverr_o;
		psel_i    <= 1'b0;
		penable_i <= 1'b0;
		if (n >= 20) begin
			errors++;
			close_out();
		end
	endtask : apb
	task automatic op(input logic [31:0] cmd);
		int n;
		n = 0;
		apb(1'b1, shc_pkg::ADDR_CMD, cmd);
		do begin
			apb(1'b0, shc_pkg::ADDR_STAT, 32'h0);
			n++;
		end while (rv[0] !== 1'b0 && n < 40);
		if (n >= 40) begin
			errors++;
			close_out();
		end
	endtask : op
	initial begin
		logic [15:0] c;
		logic [10:0] d;
		logic [7:0]  a;
		int          i, m, cw, p, q;
		repeat (16) @(posedge ref_clk_i);
		nrst_i <= 1'b1;
		apb(1'b0, shc_pkg::ADDR_INFO, 32'h0);
		chk(rv, info(8));
		apb(1'b0, shc_pkg::ADDR_DEC, 32'h0);
		chk(rv, 32'h0);
		apb(1'b0, 8'h3C, 32'h0);
		chk(32'(lerr), 32'h1);
		apb(1'b1, shc_pkg::ADDR_IMASK, 32'h1 << shc_pkg::IRQ_OP);
		for (i = 0; i < 22; i++) begin
			m = i % 11 + 1;
			cw = m + kof(m) + 1;
			d = 11'(rnd() & ((1 << m) - 1));
			c = enc(m, d);
			p = rnd() % cw;
			q = (p + 1 + rnd() % (cw - 1)) % cw;
			apb(1'b1, shc_pkg::ADDR_CTRL, 32'(m));
			apb(1'b0, shc_pkg::ADDR_INFO, 32'h0);
			chk(rv, info(m));
			apb(1'b1, shc_pkg::ADDR_WDATA, 32'(d));
			apb(1'b0, shc_pkg::ADDR_ENC, 32'h0);
			chk(rv, {16'h0, c});
			apb(1'b1, shc_pkg::ADDR_CODE, {16'h0, c ^ (16'h1 << p)});
			apb(1'b0, shc_pkg::ADDR_DEC, 32'h0);
			chk(rv, dec(d, shc_pkg::ST_CORR));
			apb(1'b1, shc_pkg::ADDR_CODE, {16'h0, c ^ (16'h1 << p) ^ (16'h1 << q)});
			apb(1'b0, shc_pkg::ADDR_DEC, 32'h0);
			chk(32'(rv[17:16]), 32'(shc_pkg::ST_DBL));
			apb(1'b1, shc_pkg::ADDR_CODE, {16'h0, c});
			apb(1'b0, shc_pkg::ADDR_DEC, 32'h0);
			chk(rv, dec(d, shc_pkg::ST_OK));
			apb(1'b1, shc_pkg::ADDR_CTRL, 32'(m) | (32'h1 << shc_pkg::CTRL_DET_BIT));
			for (p = 0; p < 3; p++) begin
				apb(1'b1, shc_pkg::ADDR_CODE, {16'h0, c ^ (p == 0 ? 16'h4 : p == 1 ? 16'h7 : 16'h5)});
				apb(1'b0, shc_pkg::ADDR_DEC, 32'h0);
				chk(rv, dec(d ^ 11'h1, p == 2 ? shc_pkg::ST_DBL : shc_pkg::ST_CORR));
			end
			apb(1'b1, shc_pkg::ADDR_CTRL, 32'(m));
			a = rnd() & 8'hF0;
			slow <= rnd() & 1;
			apb(1'b1, shc_pkg::ADDR_SADDR, 32'(a));
			op(32'h1);
			chk(32'(rv[5:4]), 32'(shc_pkg::ST_OK));
			apb(1'b0, shc_pkg::ADDR_SADDR, 32'h0);
			chk(rv, 32'(a) + (cw > 8 ? 32'h2 : 32'h1));
			chk(32'(i_mem.mem[a]), 32'(c[7:0]));
			if (cw > 8) chk(32'(i_mem.mem[a + 8'h1]), 32'(c[15:8]));
			chk(32'(irq_o), 32'h1);
			apb(1'b1, shc_pkg::ADDR_ISTAT, 32'h1F);
			apb(1'b1, shc_pkg::ADDR_CODE, {16'h0, c});
			repeat (2) @(posedge ref_clk_i);
			chk(32'(irq_o), 32'h0);
			flip <= 8'h1 << (rnd() % (cw < 8 ? cw : 8));
			apb(1'b1, shc_pkg::ADDR_SADDR, 32'(a));
			op(32'h2);
			chk(32'(rv[5:4]), 32'(shc_pkg::ST_CORR));
			apb(1'b0, shc_pkg::ADDR_DEC, 32'h0);
			chk(rv, dec(d, shc_pkg::ST_CORR));
			apb(1'b0, shc_pkg::ADDR_SADDR, 32'h0);
			chk(rv, 32'(a) + (cw > 8 ? 32'h2 : 32'h1));
			flip <= 8'h03;
			apb(1'b1, shc_pkg::ADDR_SADDR, 32'(a));
			op(32'h2);
			chk(32'(rv[5:4]), 32'(shc_pkg::ST_DBL));
			apb(1'b0, shc_pkg::ADDR_ISTAT, 32'h0);
			chk(32'(rv[shc_pkg::IRQ_DERR]), 32'h1);
			flip <= 8'h00;
			apb(1'b1, shc_pkg::ADDR_ISTAT, 32'h1F);
		end
		close_out();
	end
endmodule : secded_hamming_codec_bench
`default_nettype wire
